// >>> rtl/mrr_regs.svh
/*
  Register offsets, field positions and reset values of the
  measurement result register bank.
  Assumes inclusion by bare name from design files.
*/
`ifndef MRR_REGS_SVH
`define MRR_REGS_SVH

`define MRR_ADDR_OC_THRESH   6'h06
`define MRR_ADDR_CURR_HIGH   6'h10
`define MRR_ADDR_CURR_LOW    6'h11
`define MRR_ADDR_VOLT_HIGH   6'h12
`define MRR_ADDR_VOLT_LOW    6'h13
`define MRR_ADDR_AUX_HIGH    6'h14
`define MRR_ADDR_AUX_LOW     6'h15

`define MRR_OC_THRESH_RESET  8'hff
`define MRR_OC_THRESH_MIN    8'h10
`define MRR_RESULT_RESET     12'h000

`define MRR_BIT_INT          5
`define MRR_BIT_WARN         6

`endif

// >>> rtl/mrr_pkg.sv
/*
  Types shared by the measurement result register bank.
  Assumes nothing of its surroundings.
*/
package mrr_pkg;

  typedef logic [11:0] mrr_result_t;
  typedef logic [7:0]  mrr_byte_t;
  typedef logic [5:0]  mrr_addr_t;

  typedef enum logic [1:0]
  {
    MRR_CH_CURR,
    MRR_CH_VOLT,
    MRR_CH_AUX
  } mrr_chan_t;

endpackage : mrr_pkg

// >>> rtl/mrr_result_store.sv
/*
  Holds the three 12-bit results, one word per channel, written
  as a whole word so both bytes always come from one conversion.
  Read data come out of a register one cycle after the address.
  Assumes the writer presents a word and channel in one cycle.
*/
`timescale 1ns/1ps
`include "mrr_regs.svh"

module mrr_result_store
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                wr_en,
  input  wire mrr_pkg::mrr_chan_t  wr_chan,
  input  wire mrr_pkg::mrr_result_t wr_data,
  input  wire mrr_pkg::mrr_chan_t  rd_chan,
  output logic [11:0]              rd_data_q
);

  mrr_pkg::mrr_result_t mem_q [3];
  mrr_pkg::mrr_result_t mem_d [3];
  logic [11:0]          rd_data_d;

  ////////////////////////////////////////////////////////////////////
  // Per-word next value; whole word written at once
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_word
      always_comb
      begin
        mem_d[gi] = mem_q[gi];
        if (wr_en && (int'(wr_chan) == gi))
          mem_d[gi] = wr_data;
      end

      always_ff @(posedge clk)
      begin
        if (!reset_n)
          mem_q[gi] <= `MRR_RESULT_RESET;
        else
          mem_q[gi] <= mem_d[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Registered read port
  always_comb
  begin
    case (rd_chan)
      mrr_pkg::MRR_CH_CURR: rd_data_d = mem_q[0];
      mrr_pkg::MRR_CH_VOLT: rd_data_d = mem_q[1];
      mrr_pkg::MRR_CH_AUX:  rd_data_d = mem_q[2];
      default:              rd_data_d = 12'h000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rd_data_q <= 12'h000;
    else
      rd_data_q <= rd_data_d;
  end

endmodule : mrr_result_store

// >>> rtl/mrr_status_sync.sv
/*
  Two-flop synchroniser for the asynchronous status inputs.
  Assumes inputs come from analog comparators outside clk.
*/
`timescale 1ns/1ps

module mrr_status_sync
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [6:0] async_in,
  output logic [6:0]      sync_q
);

  logic [6:0] meta_q;
  logic [6:0] meta_d;
  logic [6:0] sync_d;

  ////////////////////////////////////////////////////////////////////
  // First stage read only by the second
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_q <= 7'h00;
      sync_q <= 7'h00;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

endmodule : mrr_status_sync

// >>> rtl/mrr_bank.sv
/*
  Measurement result register bank: over-current threshold and
  the three channel results with interrupt and warning flags.
  Assumes a register port already decoded from the serial link
  (address, read strobe, write strobe, byte data), results from
  the ADC sequencer on clk, and asynchronous status levels.
*/
`timescale 1ns/1ps
`include "mrr_regs.svh"

// Notes on behaviour
// - Threshold register is eight bits, read-write, one millivolt per code.
// - Current high byte bits 3:0 carry result bits 11:8.
// - Current low byte, next address, carries result bits 7:0.
// - Current code scales as 1.22 mV over shunt times gain.
// - Voltage high byte bits 3:0 carry result bits 11:8.
// - Voltage low byte carries result bits 7:0.
// - Voltage code scales as 1.22 mV over channel gain.
// - Auxiliary high byte bits 3:0 carry result bits 11:8.
// - Auxiliary low byte carries result bits 7:0.
// - High-byte bit 5 reads inverse of the interrupt pin.
// - Current bit 6 flags over-temperature, under-voltage or over-current.
// - Voltage bit 6 flags over-temperature, under-voltage or over-voltage.
// - Auxiliary bit 6 flags over-temperature or auxiliary under/over.
// - Result registers are read-only and reset to zero.
module mrr_bank
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire mrr_pkg::mrr_addr_t   reg_addr,
  input  wire logic                 reg_rd,
  input  wire logic                 reg_wr,
  input  wire mrr_pkg::mrr_byte_t   reg_wdata,
  input  wire logic                 res_valid,
  input  wire mrr_pkg::mrr_chan_t   res_chan,
  input  wire mrr_pkg::mrr_result_t res_data,
  input  wire logic                 int_pending,
  input  wire logic                 over_temp,
  input  wire logic                 under_volt,
  input  wire logic                 over_curr,
  input  wire logic                 over_volt,
  input  wire logic                 aux_under,
  input  wire logic                 aux_over,
  output logic [7:0]                reg_rdata_q,
  output logic                      reg_rvalid_q,
  output logic [7:0]                oc_thresh_q,
  output logic                      interrupt_out_n_q
);

  logic [7:0]           oc_thresh_d;
  logic [7:0]           reg_rdata_d;
  logic                 reg_rvalid_d;
  logic                 interrupt_out_n_d;
  logic [6:0]           stat_q;
  logic [11:0]          store_rd;
  logic [11:0]          snap_q;
  logic [11:0]          snap_d;
  mrr_pkg::mrr_chan_t   rd_chan;
  logic                 rd_high;
  logic                 rd_low;
  logic                 rd_res_q;
  logic                 rd_res_d;
  logic                 rd_res_high_q;
  logic                 rd_res_high_d;
  logic [7:0]           hold_q;
  logic [7:0]           hold_d;
  logic [7:0]           flags_d;
  logic [7:0]           flags_q;
  logic                 warn_curr;
  logic                 warn_volt;
  logic                 warn_aux;
  mrr_pkg::mrr_chan_t   rd_chan_q;
  mrr_pkg::mrr_chan_t   rd_chan_d;
  logic                 rd_pend_q;
  mrr_pkg::mrr_chan_t   snap_chan_q;
  mrr_pkg::mrr_chan_t   snap_chan_d;

  ////////////////////////////////////////////////////////////////////
  // Status pins arrive from analog comparators, so synchronise
  mrr_status_sync u_sync
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({aux_over, aux_under, over_volt, over_curr,
                under_volt, over_temp, int_pending}),
    .sync_q   (stat_q)
  );

  ////////////////////////////////////////////////////////////////////
  // Result words, written whole by the sequencer
  mrr_result_store u_store
  (
    .clk       (clk),
    .reset_n   (reset_n),
    .wr_en     (res_valid),
    .wr_chan   (res_chan),
    .wr_data   (res_data),
    .rd_chan   (rd_chan),
    .rd_data_q (store_rd)
  );

  ////////////////////////////////////////////////////////////////////
  // Address decode onto channel and byte
  always_comb
  begin
    rd_chan = mrr_pkg::MRR_CH_CURR;
    rd_high = 1'b0;
    rd_low  = 1'b0;
    case (reg_addr)
      `MRR_ADDR_CURR_HIGH:
      begin
        rd_chan = mrr_pkg::MRR_CH_CURR;
        rd_high = 1'b1;
      end
      `MRR_ADDR_CURR_LOW:
      begin
        rd_chan = mrr_pkg::MRR_CH_CURR;
        rd_low  = 1'b1;
      end
      `MRR_ADDR_VOLT_HIGH:
      begin
        rd_chan = mrr_pkg::MRR_CH_VOLT;
        rd_high = 1'b1;
      end
      `MRR_ADDR_VOLT_LOW:
      begin
        rd_chan = mrr_pkg::MRR_CH_VOLT;
        rd_low  = 1'b1;
      end
      `MRR_ADDR_AUX_HIGH:
      begin
        rd_chan = mrr_pkg::MRR_CH_AUX;
        rd_high = 1'b1;
      end
      `MRR_ADDR_AUX_LOW:
      begin
        rd_chan = mrr_pkg::MRR_CH_AUX;
        rd_low  = 1'b1;
      end
      default:
      begin
        rd_chan = mrr_pkg::MRR_CH_CURR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Warning terms per channel and the interrupt pin
  always_comb
  begin
    warn_curr = stat_q[1] | stat_q[2] | stat_q[3];
    warn_volt = stat_q[1] | stat_q[2] | stat_q[4];
    warn_aux  = stat_q[1] | stat_q[5] | stat_q[6];
    interrupt_out_n_d = ~stat_q[0];
  end

  ////////////////////////////////////////////////////////////////////
  // Threshold write; result space has no write path at all
  always_comb
  begin
    oc_thresh_d = oc_thresh_q;
    if (reg_wr && (reg_addr == `MRR_ADDR_OC_THRESH))
      oc_thresh_d = reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////
  // Read pipeline: stage one fetches the word, stage two formats.
  // Reading the high byte snapshots the word, and the low byte of
  // that channel then comes from the snapshot, so a conversion
  // landing between the two reads cannot tear the value.
  always_comb
  begin
    rd_res_d      = reg_rd & (rd_high | rd_low);
    rd_res_high_d = rd_high;
    rd_chan_d     = rd_chan;
    snap_d        = snap_q;
    hold_d        = 8'h00;
    flags_d       = 8'h00;
    snap_chan_d   = snap_chan_q;
    if (reg_rd && (reg_addr == `MRR_ADDR_OC_THRESH))
      hold_d = oc_thresh_q;
    if (reg_rd && rd_high)
    begin
      // Taken from the pin itself so the bit shows the pin as it stood at the read strobe
      flags_d[`MRR_BIT_INT] = ~interrupt_out_n_q;
      case (rd_chan)
        mrr_pkg::MRR_CH_CURR: flags_d[`MRR_BIT_WARN] = warn_curr;
        mrr_pkg::MRR_CH_VOLT: flags_d[`MRR_BIT_WARN] = warn_volt;
        mrr_pkg::MRR_CH_AUX:  flags_d[`MRR_BIT_WARN] = warn_aux;
        default:              flags_d[`MRR_BIT_WARN] = 1'b0;
      endcase
    end
    if (rd_res_q && rd_res_high_q)
    begin
      snap_d      = store_rd;
      snap_chan_d = rd_chan_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output formatting of the second stage
  always_comb
  begin
    reg_rdata_d  = hold_q;
    reg_rvalid_d = rd_pend_q;
    if (rd_res_q)
    begin
      if (rd_res_high_q)
        reg_rdata_d = {flags_q[7:4], store_rd[11:8]};
      else if (snap_q != store_rd && rd_chan_q == snap_chan_q)
        reg_rdata_d = snap_q[7:0];
      else
        reg_rdata_d = store_rd[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers of the bank
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      oc_thresh_q       <= `MRR_OC_THRESH_RESET;
      reg_rdata_q       <= 8'h00;
      reg_rvalid_q      <= 1'b0;
      interrupt_out_n_q <= 1'b1;
      snap_q            <= `MRR_RESULT_RESET;
      rd_res_q          <= 1'b0;
      rd_res_high_q     <= 1'b0;
      hold_q            <= 8'h00;
      flags_q           <= 8'h00;
      rd_chan_q         <= mrr_pkg::MRR_CH_CURR;
      rd_pend_q         <= 1'b0;
      snap_chan_q       <= mrr_pkg::MRR_CH_CURR;
    end
    else
    begin
      oc_thresh_q       <= oc_thresh_d;
      reg_rdata_q       <= reg_rdata_d;
      reg_rvalid_q      <= reg_rvalid_d;
      interrupt_out_n_q <= interrupt_out_n_d;
      snap_q            <= snap_d;
      rd_res_q          <= rd_res_d;
      rd_res_high_q     <= rd_res_high_d;
      hold_q            <= hold_d;
      flags_q           <= flags_d;
      rd_chan_q         <= rd_chan_d;
      rd_pend_q         <= reg_rd;
      snap_chan_q       <= snap_chan_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_rvalid_delay: assert property (
    reg_rd |-> ##2 reg_rvalid_q)
    else $error("read answer not two cycles after strobe");

  // Bit 5 is taken two edges before it shows on the read data
  a_int_mirror: assert property (
    rd_res_q && rd_res_high_q |=>
      reg_rdata_q[5] == !$past(interrupt_out_n_q, 2))
    else $error("interrupt bit does not mirror pin");

  a_spare_zero: assert property (
    $past(rd_res_q) && $past(rd_res_high_q) |->
      reg_rdata_q[7] == 1'b0 && reg_rdata_q[4] == 1'b0)
    else $error("spare bits of high byte not zero");

  a_thresh_write: assert property (
    reg_wr && reg_addr == `MRR_ADDR_OC_THRESH |=>
      oc_thresh_q == $past(reg_wdata))
    else $error("threshold write not stored");

  a_thresh_hold: assert property (
    !(reg_wr && reg_addr == `MRR_ADDR_OC_THRESH) |=> $stable(oc_thresh_q))
    else $error("threshold changed without write");

  a_thresh_read: assert property (
    reg_rd && reg_addr == `MRR_ADDR_OC_THRESH && !reg_wr |->
      ##2 reg_rdata_q == $past(oc_thresh_q, 2))
    else $error("threshold read returns wrong value");

  a_curr_high: assert property (
    reg_rd && reg_addr == `MRR_ADDR_CURR_HIGH && !res_valid |=>
      ##1 reg_rdata_q[3:0] == $past(store_rd[11:8]))
    else $error("current high nibble wrong");

  a_pin_follow: assert property (
    stat_q[0] |=> !interrupt_out_n_q)
    else $error("interrupt pin not asserted");

  a_warn_curr: assert property (
    reg_rd && reg_addr == `MRR_ADDR_CURR_HIGH && warn_curr |->
      ##1 flags_q[6])
    else $error("current warning flag missing");

  a_warn_aux: assert property (
    reg_rd && reg_addr == `MRR_ADDR_AUX_HIGH && !warn_aux |->
      ##1 !flags_q[6])
    else $error("auxiliary warning flag false");

  a_warn_volt: assert property (
    reg_rd && reg_addr == `MRR_ADDR_VOLT_HIGH && warn_volt |->
      ##1 flags_q[6])
    else $error("voltage warning flag missing");

  // Low byte of another channel than the snapshot comes live
  a_low_byte: assert property (
    rd_res_q && !rd_res_high_q && rd_chan_q != snap_chan_q |=>
      reg_rdata_q == $past(store_rd[7:0]))
    else $error("low byte not taken from stored word");

  // Low byte after a high read of that channel uses the snapshot
  a_snap_hold: assert property (
    rd_res_q && !rd_res_high_q && rd_chan_q == snap_chan_q |=>
      reg_rdata_q == $past(snap_q[7:0]))
    else $error("low byte torn from its high byte");

  // No answer without a strobe two edges earlier
  a_rvalid_cause: assert property (
    reg_rvalid_q |-> $past(reg_rd, 2))
    else $error("read answer without a strobe");

  // Unmapped addresses read as zero
  a_unmapped_zero: assert property (
    reg_rd && !rd_high && !rd_low && reg_addr != `MRR_ADDR_OC_THRESH |->
      ##2 reg_rdata_q == 8'h00)
    else $error("unmapped address returns data");

  c_high_low: cover property (
    reg_rd && rd_high ##1 1'b1 ##1 reg_rd && rd_low);
  c_thresh_wr: cover property (
    reg_wr && reg_addr == `MRR_ADDR_OC_THRESH);
  c_res_mid: cover property (
    reg_rd && rd_high ##[1:4] res_valid ##[1:4] reg_rd && rd_low);
  c_int_read: cover property (
    rd_res_q && rd_res_high_q && flags_q[5]);
  c_snap_used: cover property (
    rd_res_q && !rd_res_high_q && rd_chan_q == snap_chan_q
    && snap_q != store_rd);

endmodule : mrr_bank

// >>> bench/mrr_host.sv
/*
  Host model on the register port: one read or one write at a time.
  Assumes one-cycle strobes and read data two cycles after reg_rd.
*/
`timescale 1ns/1ps

module mrr_host
(
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata_q,
  input  wire logic       reg_rvalid_q,
  output logic [5:0]      reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata
);
  //////////////////////////////
  // Idle lines carry junk, not a stale value
  initial
  begin
    reg_addr  = 6'h2a;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h5a;
  end

  // Single write strobe, lines scrambled after it
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // Bounded wait for rvalid; ok stays low on timeout
  task automatic rd(input logic [5:0] a, output logic [7:0] d,
                    output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge clk);
      #1;
      if (reg_rvalid_q === 1'b1)
      begin
        d  = reg_rdata_q;
        ok = 1'b1;
      end
    end
  endtask : rd
endmodule : mrr_host

// >>> bench/tb.sv
/*
  Self-checking bench for the measurement result register bank.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
`include "mrr_regs.svh"

module tb;
  logic                 clk;
  logic                 reset_n;
  logic [5:0]           reg_addr;
  logic                 reg_rd;
  logic                 reg_wr;
  logic [7:0]           reg_wdata;
  logic                 res_valid;
  mrr_pkg::mrr_chan_t   res_chan;
  mrr_pkg::mrr_result_t res_data;
  logic                 int_pending;
  logic [5:0]           flags;
  logic [7:0]           reg_rdata_q;
  logic                 reg_rvalid_q;
  logic [7:0]           oc_thresh_q;
  logic                 interrupt_out_n_q;
  int                   errors;
  int                   total_checks;

  mrr_bank DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .res_valid(res_valid), .res_chan(res_chan), .res_data(res_data),
    .int_pending(int_pending), .over_temp(flags[0]),
    .under_volt(flags[1]), .over_curr(flags[2]), .over_volt(flags[3]),
    .aux_under(flags[4]), .aux_over(flags[5]),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .oc_thresh_q(oc_thresh_q), .interrupt_out_n_q(interrupt_out_n_q));

  mrr_host host (.clk(clk), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata));

  // 25 MHz clock
  always #20 clk = ~clk;

  //////////////////////////////
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  // A lost answer ends the run at once
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    if (!ok)
    begin
      errors++;
      stop_test();
    end
    else
      chk($sformatf("reg %h", a), d, e);
  endtask : rdchk

  task automatic post(input mrr_pkg::mrr_chan_t c, input logic [11:0] r);
    @(posedge clk);
    res_valid <= 1'b1;
    res_chan  <= c;
    res_data  <= r;
    @(posedge clk);
    res_valid <= 1'b0;
    res_data  <= ~r;
  endtask : post

  //////////////////////////////
  task automatic t_reset();
    chk("thresh", oc_thresh_q, 8'hff);
    chk("pin", {7'h00, interrupt_out_n_q}, 8'h01);
    rdchk(`MRR_ADDR_OC_THRESH, 8'hff);
    for (int a = 16; a < 22; a++) rdchk(6'(a), 8'h00);
  endtask : t_reset

  // Codes kept above 0x10; reset covers the top code
  task automatic t_thresh();
    logic [7:0] v [3] = '{8'h11, 8'hfe, 8'h5a};
    for (int i = 0; i < 3; i++)
    begin
      host.wr(`MRR_ADDR_OC_THRESH, v[i]);
      @(posedge clk);
      #1;
      chk("thresh", oc_thresh_q, v[i]);
      rdchk(`MRR_ADDR_OC_THRESH, v[i]);
    end
  endtask : t_thresh

  // Writes elsewhere must leave the threshold and the written addresses from 0x10 up alone; 0x07 is written but not read back
  task automatic t_ro();
    logic [5:0] a [5] = '{6'h07, 6'h10, 6'h13, 6'h15, 6'h3f};
    for (int i = 0; i < 5; i++) host.wr(a[i], 8'hff);
    rdchk(`MRR_ADDR_OC_THRESH, 8'h5a);
    for (int i = 1; i < 5; i++) rdchk(a[i], 8'h00);
  endtask : t_ro

  // Sign bit set and clear, both bytes per channel
  task automatic t_results();
    mrr_pkg::mrr_chan_t c [3] = '{mrr_pkg::MRR_CH_CURR,
      mrr_pkg::MRR_CH_VOLT, mrr_pkg::MRR_CH_AUX};
    logic [11:0] r [3] = '{12'h8a5, 12'h7ff, 12'h801};
    for (int i = 0; i < 3; i++)
    begin
      post(c[i], r[i]);
      rdchk(6'(16 + 2 * i), {4'h0, r[i][11:8]});
      rdchk(6'(17 + 2 * i), r[i][7:0]);
    end
  endtask : t_results

  // Each warning source alone against each channel
  task automatic t_flags();
    logic [7:0] hi [3] = '{8'h08, 8'h07, 8'h08};
    logic [5:0] m [3] = '{6'b000111, 6'b001011, 6'b110001};
    @(posedge clk);
    int_pending <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("pin", {7'h00, interrupt_out_n_q}, 8'h00);
    for (int i = 0; i < 3; i++) rdchk(6'(16 + 2 * i), hi[i] | 8'h20);
    @(posedge clk);
    int_pending <= 1'b0;
    for (int s = 0; s < 6; s++)
    begin
      @(posedge clk);
      flags <= 6'(1 << s);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 3; i++)
        rdchk(6'(16 + 2 * i), hi[i] | {1'b0, m[i][s], 6'h00});
    end
    @(posedge clk);
    flags <= 6'h00;
    repeat (4) @(posedge clk);
    #1;
    chk("pin", {7'h00, interrupt_out_n_q}, 8'h01);
  endtask : t_flags

  // New result lands between high and low reads
  task automatic t_snap();
    rdchk(`MRR_ADDR_CURR_HIGH, 8'h08);
    post(mrr_pkg::MRR_CH_CURR, 12'h3c4);
    rdchk(`MRR_ADDR_CURR_LOW, 8'ha5);
    rdchk(`MRR_ADDR_CURR_HIGH, 8'h03);
    rdchk(`MRR_ADDR_CURR_LOW, 8'hc4);
  endtask : t_snap

  // Reset mid-run must clear posted results and reload the threshold to 0xff
  task automatic t_rerun();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
  endtask : t_rerun

  // Main sequence
  initial
  begin
    clk         = 1'b0;
    reset_n     = 1'b0;
    res_valid   = 1'b0;
    res_chan    = mrr_pkg::MRR_CH_CURR;
    res_data    = 12'h000;
    int_pending = 1'b0;
    flags       = 6'h00;
    errors      = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_thresh();
    t_ro();
    t_results();
    t_flags();
    t_snap();
    t_rerun();
    stop_test();
  end
endmodule : tb
